// ---- sdram_power_clock_state_ctrl.v ----
/*
  Device-side power state tracker: samples the link clock, CKE, CS and
  the low command bits, decodes power-down, deepest sleep and no-op.
  Assumes the controller keeps its own timing obligations; the link
  clock is asynchronous to i_clk and slow enough to be oversampled.
*/
`timescale 1ns/1ps
`include "sdram_pwr_map.vh"

module sdram_power_clock_state_ctrl
(
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rstn,
  // Link pins
  input  wire       i_clock_true_line,
  input  wire       i_clock_complement_line,
  input  wire       i_cke,
  input  wire       i_cs_n,
  input  wire       i_cmd_addr_bit_zero,
  input  wire       i_cmd_addr_bit_one,
  input  wire       i_cmd_addr_bit_two,
  // Status
  input  wire       i_init_done,
  input  wire       i_op_busy,
  output reg  [3:0] o_power_state,
  output reg        o_buffers_enable,
  output reg        o_core_supply_enable,
  output reg        o_contents_lost,
  output reg        o_nop_seen,
  output reg        o_ready,
  output reg        o_op_busy_hold
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  wire [6:0] pin_raw = {i_clock_true_line, i_clock_complement_line, i_cke, i_cs_n,
                        i_cmd_addr_bit_two, i_cmd_addr_bit_one, i_cmd_addr_bit_zero};
  reg  [6:0] sync1;
  reg  [6:0] sync2;
  reg        ck_prev;
  genvar     gi;

  // Two flip-flops per pin; only the second stage feeds logic
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_sync
      always @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // Link clock high only when the true line is high and the complement low, so a parked pair reads low
  wire       ck_true = sync2[6] & ~sync2[5];

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ck_prev <= 1'b0;
    else
      ck_prev <= ck_true;
  end

  wire       cke     = sync2[4];
  wire       cs_n    = sync2[3];
  wire [2:0] ca      = sync2[2:0];
  wire       ck_rise = ck_true & ~ck_prev;

  // ---------------------------------------------------------------
  // Command decode on link edges
  // ---------------------------------------------------------------
  reg        cke_prev;
  reg  [3:0] next_state;
  reg  [3:0] exit_cnt;
  wire       is_nop  = cs_n | (ca == `CA_NOP);
  wire       is_deep = ~cs_n & (ca == `CA_DEEP_SLEEP);

  always @*
  begin
    next_state = o_power_state;
    case (o_power_state)
      `ST_ACTIVE:
      begin
        if (cke_prev & ~cke & is_deep)
          next_state = `ST_DEEP_SLEEP;
        else if (cke_prev & ~cke & cs_n)
          next_state = `ST_POWERDOWN;
      end
      `ST_POWERDOWN:
      begin
        if (cke)
          next_state = `ST_ACTIVE;
      end
      `ST_DEEP_SLEEP:
      begin
        if (cke)
          next_state = `ST_NEEDINIT;
      end
      `ST_NEEDINIT:
      begin
        if (i_init_done)
          next_state = `ST_ACTIVE;
      end
      default:
        next_state = `ST_ACTIVE;
    endcase
  end

  // ---------------------------------------------------------------
  // State and status registers
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_power_state        <= `ST_ACTIVE;
      cke_prev             <= 1'b0;
      exit_cnt             <= 4'h0;
      o_contents_lost      <= 1'b0;
      o_nop_seen           <= 1'b0;
      o_op_busy_hold       <= 1'b0;
    end
    else
    begin
      o_nop_seen <= 1'b0;
      if (ck_rise)
      begin
        cke_prev      <= cke;
        o_power_state <= next_state;
        o_nop_seen    <= is_nop & (cke == cke_prev);
        // Running operation continues across no-op commands
        o_op_busy_hold <= i_op_busy;
        if (next_state == `ST_DEEP_SLEEP)
          o_contents_lost <= 1'b1;
        else if (next_state == `ST_ACTIVE && o_power_state == `ST_NEEDINIT)
          o_contents_lost <= 1'b0;
        if (next_state == `ST_ACTIVE && o_power_state == `ST_POWERDOWN)
          exit_cnt <= `EXIT_LAT_CYC;
        else if (exit_cnt != 4'h0)
          exit_cnt <= exit_cnt - 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Derived enables and readiness, one cycle behind the state
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_buffers_enable     <= 1'b1;
      o_core_supply_enable <= 1'b1;
      o_ready              <= 1'b1;
    end
    else
    begin
      o_buffers_enable     <= (o_power_state == `ST_ACTIVE) ||
                              (o_power_state == `ST_NEEDINIT);
      o_core_supply_enable <= (o_power_state != `ST_DEEP_SLEEP);
      o_ready              <= (o_power_state == `ST_ACTIVE) && (exit_cnt == 4'h0);
    end
  end

endmodule // sdram_power_clock_state_ctrl

// ---- sdram_pwr_map.vh ----
/*
  Constants for the power-state and clock-management block.
  Assumes inclusion by sdram_power_clock_state_ctrl.v only.
*/
`ifndef SDRAM_PWR_MAP_VH
`define SDRAM_PWR_MAP_VH

// Power states, one-hot
`define ST_ACTIVE     4'h1
`define ST_POWERDOWN  4'h2
`define ST_DEEP_SLEEP 4'h4
`define ST_NEEDINIT   4'h8

// Command code on cmd_addr_bit_zero..two
`define CA_DEEP_SLEEP 3'h3
`define CA_NOP        3'h7

// Exit latency in link clock cycles (powerdown_exit_latency)
`define EXIT_LAT_CYC  4'h3

`endif

// ---- sdram_pwr_checker.sv ----
/* Port checker for the power tracker; assumes bind into the design top. */
`timescale 1ns/1ps
module sdram_pwr_checker (
  input wire       i_clk,
  input wire       i_rstn,
  input wire [3:0] o_power_state,
  input wire       o_buffers_enable,
  input wire       o_core_supply_enable,
  input wire       o_contents_lost,
  input wire       o_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_hot; $onehot(o_power_state); endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_off; o_power_state[2] |=> !o_buffers_enable && !o_core_supply_enable; endproperty
  a_off: assert property (p_off) else $error("sleep powered");
  property p_lost; o_power_state[2] |-> o_contents_lost; endproperty
  a_lost: assert property (p_lost) else $error("lost flag low");
  property p_din; $rose(o_power_state[2]) |-> $past(o_power_state[0]); endproperty
  a_din: assert property (p_din) else $error("bad sleep entry");
  property p_dout; $fell(o_power_state[2]) |-> o_power_state[3]; endproperty
  a_dout: assert property (p_dout) else $error("bad sleep exit");
  property p_pdin; $rose(o_power_state[1]) |-> $past(o_power_state[0]); endproperty
  a_pdin: assert property (p_pdin) else $error("bad power down entry");
  property p_pd; o_power_state[1] |=> !o_buffers_enable && o_core_supply_enable; endproperty
  a_pd: assert property (p_pd) else $error("power down enables");
  property p_rdy; o_ready |-> $past(o_power_state[0]); endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside active");
endmodule // sdram_pwr_checker
bind sdram_power_clock_state_ctrl sdram_pwr_checker u_chk (.*);

// ---- sdram_link_model.sv ----
/* Controller model: one link clock cycle per command, clock parked between. */
`timescale 1ns/1ps
module sdram_link_model (
  input  wire       i_clk,
  output reg  [1:0] o_ck,
  output reg        o_cke,
  output reg        o_cs_n,
  output reg  [2:0] o_ca
);
  initial {o_ck, o_cke, o_cs_n, o_ca} = 7'h28;
  task tx(input c, input s, input [2:0] a);
    begin
      @(negedge i_clk);
      {o_cke, o_cs_n, o_ca} = {c, s, a};
      #80 o_ck = 2'h2;
      #80 o_ck = 2'h1;
      o_ca = ~a;
      o_cs_n = 1'b1;
    end
  endtask
endmodule // sdram_link_model

// ---- tb_sdram_power_clock_state_ctrl.sv ----
/* Bench: link model drives the pins; checks decoded power state. */
`timescale 1ns/1ps
module tb_sdram_power_clock_state_ctrl;
  reg        i_clk = 0, i_rstn = 0, i_init_done = 0, i_op_busy = 0;
  reg  [3:0] nops = 0, n = 0;
  wire       i_clock_true_line, i_clock_complement_line, i_cke, i_cs_n;
  wire       i_cmd_addr_bit_zero, i_cmd_addr_bit_one, i_cmd_addr_bit_two;
  wire       o_buffers_enable, o_core_supply_enable, o_contents_lost;
  wire       o_nop_seen, o_ready, o_op_busy_hold;
  wire [3:0] o_power_state;
  integer    failures = 0, tests_run = 0;
  // Command-to-power-down gaps in link cycles; values are plain defaults
  localparam [3:0] GAP_WR_AP = 4'h9;
  localparam [3:0] GAP_REF   = 4'h1;
  localparam [3:0] GAP_MRR   = 4'h8;
  localparam [3:0] GAP_MRW   = 4'h5;
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) if (o_nop_seen === 1'b1) nops = nops + 4'h1;
  sdram_link_model u_ctl (.i_clk(i_clk), .o_ck({i_clock_true_line, i_clock_complement_line}),
    .o_cke(i_cke), .o_cs_n(i_cs_n),
    .o_ca({i_cmd_addr_bit_two, i_cmd_addr_bit_one, i_cmd_addr_bit_zero}));
  sdram_power_clock_state_ctrl u_dut (.*);
  task chk(input string name, input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task t_deep;
    begin
      u_ctl.tx(1, 1, 3'h7);
      u_ctl.tx(0, 0, 3'h3);
      chk("deep", {o_power_state, o_buffers_enable, o_core_supply_enable, o_contents_lost}, 7'h21);
      n = nops;
      u_ctl.tx(0, 1, 3'h7);
      u_ctl.tx(0, 1, 3'h7);
      u_ctl.tx(1, 1, 3'h7);
      chk("exit", {o_power_state, nops - n}, 8'h82);
      i_init_done = 1;
      u_ctl.tx(1, 1, 3'h7);
      i_init_done = 0;
      chk("init", {o_power_state, o_contents_lost}, 5'h02);
    end
  endtask
  task t_pd;
    begin
      u_ctl.tx(0, 1, 3'h7);
      u_ctl.tx(0, 0, 3'h3);
      chk("pd", {o_power_state, o_buffers_enable}, 5'h04);
      n = nops;
      u_ctl.tx(1, 1, 3'h7);
      chk("wake", {o_ready, nops - n}, 5'h00);
      i_op_busy = 1;
      repeat (4) u_ctl.tx(1, 0, 3'h7);
      chk("run", {o_power_state, o_ready, o_op_busy_hold, nops - n}, 10'h074);
      i_op_busy = 0;
    end
  endtask
  task t_gap(input [2:0] cmd, input [3:0] gap);
    begin
      u_ctl.tx(1, 0, cmd);
      n = nops;
      repeat (gap) u_ctl.tx(1, 1, 3'h7);
      u_ctl.tx(0, 1, 3'h7);
      chk("gap", {o_power_state, nops - n}, {4'h2, gap});
      u_ctl.tx(1, 1, 3'h7);
      repeat (3) u_ctl.tx(1, 1, 3'h7);
    end
  endtask
  initial
  begin
    repeat (10) @(negedge i_clk);
    i_rstn = 1;
    t_deep;
    t_gap(3'h0, GAP_MRW);
    t_pd;
    t_gap(3'h1, GAP_WR_AP);
    t_gap(3'h4, GAP_REF);
    t_gap(3'h0, GAP_MRR);
    finish_test;
  end
  initial
  begin
    #100000;
    failures = failures + 1;
    finish_test;
  end
endmodule // tb_sdram_power_clock_state_ctrl
